// ==== rtl/sew_access.sv ====
// Serial 3-wire access logic of a 16-bit word EEPROM, sampled on clk
// Pins pass two flops; serial_clock_n period is far longer than clk
//
// Function
// - Array of 16-bit words, 128/256/512 deep
// - Opcode byte, address byte, then two data bytes
// - Sample on rising edge, shift on falling
// - Select with clock high: command; low: status
// - Status ends on deselect or first 1
// - Output floats except status or read data
// - Deselect mid-command abandons the command
// - Read A8, write A4; small part addr then 0
// - Largest part: opcode last bit is address_bit_top
// - Sixteen data bits, busy after 32nd edge
// - Writes disabled at reset until enable command
// - Reads work regardless of write enable
// - Reset pin high refuses writes only
// - Reset pin high aborts programming to ready
// - Programming needs no clock edges nor select
// - Read output from 17th falling edge, MSB first
// - Sequential read increments address with wrap
`timescale 1ns/1ps
`include "sew_defines.svh"
module sew_access
  import sew_pkg::*;
#(
  parameter int AW         = 9,
  parameter int PROG_CYCLES = `SEW_PROG_CYCLES
)(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic chip_select_n,
  input  wire logic serial_clock_n,
  input  wire logic serial_in,
  input  wire logic reset_pin,
  output logic      serial_out,
  output logic      serial_out_oe,
  output logic      busy
);
  logic              cs_q;
  logic              sk_q;
  logic              cs_n_s;
  logic              sk_s;
  logic              di_s;
  logic              rst_s;
  logic              cs_n_d_ff;
  logic              sk_d_ff;
  sew_state_e        state_ff;
  logic [5:0]        bit_cnt_ff;
  logic [7:0]        op_ff;
  logic [AW-1:0]     addr_ff;
  logic [15:0]       data_ff;
  logic [15:0]       rd_sh_ff;
  logic [4:0]        rd_cnt_ff;
  logic              wen_ff;
  logic [31:0]       prog_cnt_ff;
  logic [AW-1:0]     prog_addr_ff;
  logic [15:0]       prog_data_ff;
  logic              arr_we;
  logic [15:0]       arr_rdata;
  logic              cs_fall;
  logic              cs_rise;
  logic              sk_rise;
  logic              sk_fall;
  logic [7:0]        nxt_op;
  logic [AW-1:0]     nxt_addr;
  logic [15:0]       nxt_data;

  sew_sync #(.W(4)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({!chip_select_n, !serial_clock_n, serial_in, reset_pin}),
    .q    ({cs_q, sk_q, di_s, rst_s})
  );

  // Active-low pins pass the flops inverted, so cleared flops read as idle high and no false select follows reset
  assign cs_n_s = !cs_q;
  assign sk_s   = !sk_q;

  sew_array #(.AW(AW)) u_array (
    .clk   (clk),
    .we    (arr_we),
    .waddr (prog_addr_ff),
    .wdata (prog_data_ff),
    .raddr (addr_ff),
    .rdata (arr_rdata)
  );

  function automatic logic is_rw(input logic [7:0] op, input logic [7:0] code);
    // Largest variant borrows the opcode's last bit for the top address
    is_rw = (AW > 8) ? ((op & `SEW_OP_RW_MASK) == code) : (op == code);
  endfunction

  function automatic logic [AW-1:0] cmd_addr(input logic [7:0] op, input logic [7:0] fld);
    logic [8:0] full;
    full = {op[0], fld};
    if (AW == 7)
      cmd_addr = AW'(full[7:1]);
    else
      cmd_addr = AW'(full);
  endfunction

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cs_n_d_ff <= 1'b1;
      sk_d_ff   <= 1'b1;
    end
    else
    begin
      cs_n_d_ff <= cs_n_s;
      sk_d_ff   <= sk_s;
    end
  end

  assign cs_fall = cs_n_d_ff && !cs_n_s;
  assign cs_rise = !cs_n_d_ff && cs_n_s;
  assign sk_rise = !sk_d_ff && sk_s;
  assign sk_fall = sk_d_ff && !sk_s;
  assign nxt_op   = (bit_cnt_ff < 6'(`SEW_FIELD_BITS)) ? {op_ff[6:0], di_s} : op_ff;
  assign nxt_addr = cmd_addr(op_ff, data_ff[7:0]);
  assign nxt_data = {data_ff[14:0], di_s};

  // Command sequencer
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_ff   <= SEW_IDLE;
      bit_cnt_ff <= '0;
      op_ff      <= '0;
      addr_ff    <= '0;
      data_ff    <= '0;
    end
    else if (cs_rise)
    begin
      state_ff <= SEW_IDLE;
    end
    else
    begin
      case (state_ff)
        SEW_IDLE:
          if (cs_fall)
          begin
            bit_cnt_ff <= '0;
            op_ff      <= '0;
            state_ff   <= sk_s ? SEW_CMD : SEW_STATUS;
          end
        SEW_STATUS:
          if (sk_rise && di_s)
          begin
            // First opcode bit is always 1; it leaves status and starts the command
            op_ff      <= 8'h01;
            bit_cnt_ff <= 6'h01;
            state_ff   <= SEW_CMD;
          end
        SEW_CMD:
          if (sk_rise)
          begin
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
            op_ff      <= nxt_op;
            if (bit_cnt_ff >= 6'(`SEW_FIELD_BITS))
              data_ff <= nxt_data;
            if (bit_cnt_ff == `SEW_ADDR_END - 6'h01)
            begin
              if (is_rw(op_ff, `SEW_OP_READ))
              begin
                addr_ff  <= cmd_addr(op_ff, nxt_data[7:0]);
                state_ff <= SEW_READ;
              end
              else if (!is_rw(op_ff, `SEW_OP_WRITE))
                state_ff <= SEW_DONE;
              else
                addr_ff <= cmd_addr(op_ff, nxt_data[7:0]);
            end
            if (bit_cnt_ff == `SEW_DATA_END - 6'h01)
              state_ff <= SEW_DONE;
          end
        SEW_READ:
          if (sk_fall && rd_cnt_ff == 5'h01)
            addr_ff <= addr_ff + AW'(1);
        SEW_DONE:
          state_ff <= SEW_DONE;
        default:
          state_ff <= SEW_IDLE;
      endcase
    end
  end

  // Write latch and programming timer
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wen_ff       <= 1'b0;
      prog_cnt_ff  <= '0;
      prog_addr_ff <= '0;
      prog_data_ff <= '0;
      busy         <= 1'b0;
    end
    else
    begin
      if (state_ff == SEW_CMD && sk_rise && bit_cnt_ff == `SEW_ADDR_END - 6'h01)
      begin
        if (op_ff == `SEW_OP_WRITE_ENABLE_CMD)
          wen_ff <= 1'b1;
        else if (op_ff == `SEW_OP_WRITE_DISABLE_CMD)
          wen_ff <= 1'b0;
      end
      if (busy)
      begin
        // Runs without clock or select from the host
        if (rst_s || prog_cnt_ff == 32'(PROG_CYCLES - 1))
        begin
          busy        <= 1'b0;
          prog_cnt_ff <= '0;
        end
        else
          prog_cnt_ff <= prog_cnt_ff + 32'h1;
      end
      else if (state_ff == SEW_CMD && sk_rise && bit_cnt_ff == `SEW_DATA_END - 6'h01
               && is_rw(op_ff, `SEW_OP_WRITE) && wen_ff && !rst_s)
      begin
        busy         <= 1'b1;
        prog_addr_ff <= addr_ff;
        prog_data_ff <= nxt_data;
      end
    end
  end

  // Word lands at the end of the period; an abort leaves it unwritten
  assign arr_we = busy && !rst_s && prog_cnt_ff == 32'(PROG_CYCLES - 1);

  // Read shifter
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_sh_ff  <= '0;
      rd_cnt_ff <= '0;
    end
    else if (state_ff == SEW_READ && sk_fall)
    begin
      if (rd_cnt_ff == 5'h00)
      begin
        rd_sh_ff  <= arr_rdata;
        rd_cnt_ff <= `SEW_WORD_BITS - 5'h01;
      end
      else
      begin
        rd_sh_ff  <= {rd_sh_ff[14:0], 1'b0};
        rd_cnt_ff <= rd_cnt_ff - 5'h01;
      end
    end
    else if (state_ff != SEW_READ)
      rd_cnt_ff <= '0;
  end

  // Output pin
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end
    else
    begin
      if (state_ff == SEW_STATUS && !cs_rise && !(sk_rise && di_s))
      begin
        serial_out    <= !busy;
        serial_out_oe <= 1'b1;
      end
      else if (state_ff == SEW_READ && !cs_rise)
      begin
        if (sk_fall)
        begin
          serial_out    <= (rd_cnt_ff == 5'h00) ? arr_rdata[15] : rd_sh_ff[14];
          serial_out_oe <= 1'b1;
        end
      end
      else
      begin
        serial_out    <= 1'b0;
        serial_out_oe <= 1'b0;
      end
    end
  end

  a_status_drive: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == SEW_STATUS ##1 state_ff == SEW_STATUS |-> serial_out_oe && serial_out == !$past(busy))
    else $error("status output wrong");

  a_float_idle: assert property (@(posedge clk) disable iff (!nrst)
    $past(state_ff) == SEW_IDLE && state_ff == SEW_IDLE |-> !serial_out_oe)
    else $error("output driven while idle");

  a_abandon: assert property (@(posedge clk) disable iff (!nrst)
    cs_rise |=> state_ff == SEW_IDLE)
    else $error("command not abandoned");

  a_select_mode: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == SEW_IDLE && cs_fall && !cs_rise |=> state_ff == ($past(sk_s) ? SEW_CMD : SEW_STATUS))
    else $error("wrong mode on select");

  a_no_write_off: assert property (@(posedge clk) disable iff (!nrst)
    !busy && !wen_ff |=> !busy)
    else $error("busy while writes disabled");

  a_reset_abort: assert property (@(posedge clk) disable iff (!nrst)
    busy && rst_s |=> !busy ##0 !arr_we)
    else $error("programming not aborted");

  a_reset_block: assert property (@(posedge clk) disable iff (!nrst)
    rst_s && !busy |=> !busy)
    else $error("write started under reset pin");

  a_prog_len: assert property (@(posedge clk) disable iff (!nrst)
    $rose(busy) ##1 !rst_s [*8] |-> busy)
    else $error("programming ended early");

  a_read_oe: assert property (@(posedge clk) disable iff (!nrst)
    $rose(serial_out_oe) && state_ff == SEW_READ |-> $past(sk_fall))
    else $error("read output not on falling edge");

  sequence s_write_enable_cmd_done;
    state_ff == SEW_CMD && sk_rise && bit_cnt_ff == `SEW_ADDR_END - 6'h01 && op_ff == `SEW_OP_WRITE_ENABLE_CMD && !cs_rise;
  endsequence
  a_write_enable_cmd_sets: assert property (@(posedge clk) disable iff (!nrst)
    s_write_enable_cmd_done |=> wen_ff)
    else $error("write enable not latched");

endmodule // sew_access

// ==== include/sew_defines.svh ====
// Constants of the serial word EEPROM access block
// Included by the package, sew_access and the bench; definitions only
`ifndef SEW_DEFINES_SVH
`define SEW_DEFINES_SVH
`define SEW_OP_READ      8'hA8
`define SEW_OP_WRITE     8'hA4
`define SEW_OP_RW_MASK   8'hFE
`define SEW_OP_WRITE_ENABLE_CMD      8'hA3
`define SEW_OP_WRITE_DISABLE_CMD      8'hA0
`define SEW_OP_WRITE_ALL_TEST_CMD      8'hAF
`define SEW_FIELD_BITS   5'h08
`define SEW_ADDR_END     6'h10
`define SEW_DATA_END     6'h20
`define SEW_WORD_BITS    5'h10
`define SEW_PROG_MS      10
`define SEW_CLK_KHZ      10000
`define SEW_PROG_CYCLES  (`SEW_PROG_MS * `SEW_CLK_KHZ)
`endif

// ==== include/sew_pkg.sv ====
// Types of the serial word EEPROM access block
// Needs sew_defines.svh on the include path
`include "sew_defines.svh"
package sew_pkg;
  typedef enum logic [4:0] {
    SEW_IDLE   = 5'h01,
    SEW_STATUS = 5'h02,
    SEW_CMD    = 5'h04,
    SEW_READ   = 5'h08,
    SEW_DONE   = 5'h10
  } sew_state_e;
endpackage

// ==== rtl/sew_sync.sv ====
// Two-flop synchroniser for the pin inputs
// Inputs come from outside the clk domain
`timescale 1ns/1ps
module sew_sync
  import sew_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule // sew_sync

// ==== rtl/sew_array.sv ====
// Word array of the EEPROM with one read and one write port
// Contents are undefined until written
`timescale 1ns/1ps
module sew_array
  import sew_pkg::*;
#(
  parameter int AW = 9
)(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [15:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [15:0]   rdata
);
  logic [15:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end
  assign rdata = mem[raddr];
endmodule // sew_array

// ==== verif/sew_host.sv ====
// Host serial port model driving select, serial clock and data-in of the EEPROM
// Assumes clk of 100 ns; serial clock 800 ns, standing high between frames
`timescale 1ns/1ps
module sew_host
(
  input  wire logic clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output logic      chip_select_n,
  output logic      serial_clock_n,
  output logic      serial_in
);
  logic last_ff;
  logic line;

  // A released output shows the inverse of its last value, never a stale copy
  assign line = serial_out_oe ? serial_out : ~last_ff;

  always_ff @(posedge clk)
    if (serial_out_oe)
      last_ff <= serial_out;

  initial
  begin
    chip_select_n  = 1'b1;
    serial_clock_n = 1'b1;
    serial_in      = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Clock high at select fall gives a command, low gives status
  task automatic open(input logic stat);
    serial_clock_n = ~stat;
    tick(1);
    chip_select_n = 1'b0;
    tick(4);
  endtask

  // Select stays high 400 ns, above the minimum gap between commands
  task automatic close();
    chip_select_n  = 1'b1;
    serial_clock_n = 1'b1;
    tick(4);
  endtask

  // Data changes with the clock low; output is read mid high phase
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] rd);
    rd = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_clock_n = 1'b0;
      serial_in      = v[i];
      tick(4);
      serial_clock_n = 1'b1;
      tick(2);
      rd = {rd[30:0], line};
      tick(2);
    end
  endtask

  // Only the four user opcodes are ever sent, never the test-only one
  task automatic cmd(input logic [15:0] head, input logic [31:0] tail, input int n, output logic [31:0] rd);
    open(1'b0);
    shift({16'h0000, head}, 16, rd);
    shift(tail, n, rd);
    close();
  endtask
endmodule // sew_host

// ==== verif/tb_serial_eeprom_3wire_access.sv ====
// Self-checking bench of the serial word EEPROM access block, largest variant
// Assumes sew_host as the host; programming shortened to 50 clk
`timescale 1ns/1ps
`include "sew_defines.svh"
module tb_serial_eeprom_3wire_access;
  logic        clk;
  logic        nrst;
  logic        reset_pin;
  logic        chip_select_n;
  logic        serial_clock_n;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        busy;
  logic [31:0] rd;
  int          miscompares;
  int          tests_run;

  sew_access #(.AW(9), .PROG_CYCLES(50)) u_sew_access (.clk(clk), .nrst(nrst),
    .chip_select_n(chip_select_n), .serial_clock_n(serial_clock_n), .serial_in(serial_in),
    .reset_pin(reset_pin), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .busy(busy));

  sew_host u_sew_host (.clk(clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .chip_select_n(chip_select_n), .serial_clock_n(serial_clock_n), .serial_in(serial_in));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_busy(input logic v);
    for (int i = 0; i < 200 && busy !== v; i++)
      u_sew_host.tick(1);
    if (busy !== v)
    begin
      miscompares++;
      give_verdict();
    end
  endtask

  // Fewer than 16 data bits leaves the write cut short
  task automatic wr_cut(input logic [8:0] a, input logic [15:0] d, input int n);
    u_sew_host.cmd({`SEW_OP_WRITE | {7'h00, a[8]}, a[7:0]}, {16'h0000, d}, n, rd);
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    wr_cut(a, d, 16);
  endtask

  task automatic en(input logic [7:0] op);
    u_sew_host.cmd({op, 8'h5A}, 32'h00000000, 0, rd);
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [15:0] e0, input logic [15:0] e1);
    u_sew_host.cmd({`SEW_OP_READ | {7'h00, a[8]}, a[7:0]}, 32'h00000000, 32, rd);
    chk("read word", e0, rd[31:16]);
    chk("next word", e1, rd[15:0]);
  endtask

  task automatic stat_chk(input logic e);
    u_sew_host.open(1'b1);
    u_sew_host.tick(2);
    chk("status oe", 16'h0001, {15'h0000, serial_out_oe});
    chk("status", {15'h0000, e}, {15'h0000, serial_out});
    u_sew_host.close();
    chk("oe released", 16'h0000, {15'h0000, serial_out_oe});
  endtask

  task automatic t_locked();
    chk("idle oe", 16'h0000, {15'h0000, serial_out_oe});
    wr(9'h105, 16'hBEEF);
    chk("locked busy", 16'h0000, {15'h0000, busy});
  endtask

  task automatic t_write();
    en(`SEW_OP_WRITE_ENABLE_CMD);
    wr(9'h1FF, 16'hA5C3);
    wait_busy(1'b1);
    stat_chk(1'b0);
    wait_busy(1'b0);
    stat_chk(1'b1);
    wr(9'h000, 16'h1234);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd_chk(9'h1FF, 16'hA5C3, 16'h1234);
  endtask

  task automatic t_protect();
    reset_pin = 1'b1;
    wr(9'h000, 16'hFFFF);
    chk("protect busy", 16'h0000, {15'h0000, busy});
    rd_chk(9'h1FF, 16'hA5C3, 16'h1234);
    reset_pin = 1'b0;
  endtask

  task automatic t_abort();
    wr(9'h040, 16'h0F0F);
    wait_busy(1'b1);
    reset_pin = 1'b1;
    u_sew_host.tick(6);
    chk("abort busy", 16'h0000, {15'h0000, busy});
    reset_pin = 1'b0;
    stat_chk(1'b1);
  endtask

  task automatic t_disable();
    en(`SEW_OP_WRITE_DISABLE_CMD);
    wr(9'h000, 16'hFFFF);
    chk("disabled busy", 16'h0000, {15'h0000, busy});
    rd_chk(9'h1FF, 16'hA5C3, 16'h1234);
  endtask

  // Select rises after ten data bits; the word must stay untouched
  task automatic t_abandon();
    en(`SEW_OP_WRITE_ENABLE_CMD);
    wr_cut(9'h1FF, 16'h03FF, 10);
    chk("abandon busy", 16'h0000, {15'h0000, busy});
    rd_chk(9'h1FF, 16'hA5C3, 16'h1234);
  endtask

  // Status mode is left by the first opcode bit; the read then runs in the same select
  task automatic t_status_read();
    logic [31:0] w;
    int          n;
    w = {16'h0000, `SEW_OP_READ | 8'h01, 8'hFF};
    n = 16;
    u_sew_host.open(1'b1);
    u_sew_host.tick(1);
    chk("status before cmd", 16'h0001, {15'h0000, serial_out_oe});
    u_sew_host.shift(w, n, rd);
    chk("status left", 16'h0000, {15'h0000, serial_out_oe});
    u_sew_host.shift(w, n + n, rd);
    chk("status read", 16'hA5C3, rd[31:16]);
    chk("status next", 16'h1234, rd[15:0]);
    u_sew_host.close();
  endtask

  // A second reset mid-run must lock writes again and leave the output released
  task automatic t_relock();
    en(`SEW_OP_WRITE_ENABLE_CMD);
    nrst = 1'b0;
    u_sew_host.tick(5);
    nrst = 1'b1;
    u_sew_host.tick(2);
    chk("reset oe", 16'h0000, {15'h0000, serial_out_oe});
    u_sew_host.tick(3);
    wr(9'h1FF, 16'h0000);
    chk("relock busy", 16'h0000, {15'h0000, busy});
    rd_chk(9'h1FF, 16'hA5C3, 16'h1234);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    nrst        = 1'b0;
    reset_pin   = 1'b0;
    miscompares = 0;
    tests_run   = 0;
    u_sew_host.tick(5);
    nrst = 1'b1;
    u_sew_host.tick(5);
    t_locked();
    t_write();
    t_protect();
    t_abort();
    t_disable();
    t_abandon();
    t_status_read();
    t_relock();
    give_verdict();
  end
endmodule // tb_serial_eeprom_3wire_access
